// File: common/emem_map_pkg.sv
// constants, types and the operation summary of the emulation memory area mapper
// Summary of operation
// RULE_01: four expansion areas, each own settings
// RULE_02: bank value gives start address bits 23..16
// RULE_03: area length is 256 KB or 1 MB
// RULE_04: 256 KB area bank is multiple of four
// RULE_05: 1 MB area bank ends in zero
// RULE_06: internal area accesses go to expansion memory
// RULE_07: external or unused areas go to target
// RULE_08: unmapped addresses external except internal ranges
// RULE_09: loading into external areas is faster
// RULE_10: total internal length stays within 1.5 MB
// RULE_11: only permitted area size combinations used
// RULE_12: areas never overlap, avoid unusable ranges
// RULE_13: reset vector always from pod memory
// RULE_14: register and RAM ranges always internal
// RULE_15: ROM range auto mapped in non-microprocessor modes
// RULE_16: ROM range extendable to full top megabyte
// RULE_17: expansion memory needs expansion or microprocessor mode
// RULE_18: expansion mode starts in single-chip after reset
// RULE_19: report target mode and handshake pin levels
// RULE_20: low handshake pin means standby, report it
// RULE_21: hits compare upper address bits with bank
package emem_map_pkg;

  // ==========================================================
  // geometry
  localparam int          AREA_COUNT    = 4;
  localparam int          ADDR_W        = 24;
  localparam int          BANK_W        = 8;
  localparam int          IDX_W         = 2;
  localparam int          UNITS_W       = 5;
  localparam int          POS_256K      = 18;
  localparam int          POS_1M        = 20;
  localparam int          POS_BANK      = 16;
  localparam logic [2:0]  UNITS_256K    = 3'h1;
  localparam logic [2:0]  UNITS_1M      = 3'h4;
  localparam logic [4:0]  UNITS_MAX     = 5'h06;
  localparam logic [1:0]  MAX_1M_AREAS  = 2'h1;
  localparam logic [2:0]  MAX_256K_WITH_1M = 3'h2;

  // ==========================================================
  // fixed address ranges
  localparam logic [7:0]  ROM_BANK_MIN  = 8'hf0;
  localparam logic [7:0]  ROM_BANK_RST  = 8'hf8;
  localparam logic [23:0] VECTOR_BASE   = 24'hffff00;
  localparam logic [23:0] TOP_ADDR      = 24'hffffff;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MAP_NOUSE    = 2'h0,
    MAP_INTERNAL = 2'h1,
    MAP_EXTERNAL = 2'h2
  } map_t;

  typedef enum logic [1:0] {
    CFG_SINGLE = 2'h0,
    CFG_EXPAND = 2'h1,
    CFG_MICRO  = 2'h2
  } cfg_mode_t;

  typedef enum logic [2:0] {
    RUN_SINGLE = 3'b001,
    RUN_EXPAND = 3'b010,
    RUN_MICRO  = 3'b100
  } run_mode_t;

  typedef struct packed {
    logic [7:0] bank;
    logic       len_1mb;
    map_t       map;
  } area_cfg_t;

  typedef struct packed {
    logic rom_emu;
    logic exp_emu;
    logic internal;
    logic external;
  } target_t;

  typedef struct packed {
    logic bus_width;
    logic proc_mode;
    logic wait_n;
    logic hold_n;
    logic nmi_n;
  } pin_status_t;

  localparam target_t     TARGET_RST    = 4'h0;
  localparam pin_status_t PINS_RST      = 5'h07;

endpackage : emem_map_pkg

// File: rtl/area_match.sv
// hit and legality decode for one expansion area
`timescale 1ns/1ns
module area_match
  import emem_map_pkg::*;
(
  // area settings
  input  area_cfg_t          cfg,
  // address under test
  input  wire logic [23:0]   addr,
  // decode results
  output logic               hit,
  output logic               legal
);

  // ==========================================================
  // bank alignment
  always_comb begin
    if (cfg.len_1mb) begin
      legal = (cfg.bank[3:0] == 4'h0); // RULE_05
    end else begin
      legal = (cfg.bank[1:0] == 2'h0); // RULE_04
    end
  end

  // ==========================================================
  // address compare
  // misaligned banks never hit, so a bad setting cannot shadow a neighbour
  always_comb begin
    if (cfg.map == MAP_NOUSE || !legal) begin
      hit = 1'b0;
    end else if (cfg.len_1mb) begin // RULE_03
      hit = (addr[ADDR_W-1:POS_1M] == cfg.bank[BANK_W-1:POS_1M-POS_BANK]); // RULE_21
    end else begin
      hit = (addr[ADDR_W-1:POS_256K] == cfg.bank[BANK_W-1:POS_256K-POS_BANK]); // RULE_21
    end
  end

endmodule : area_match

// File: rtl/emem_mapper.sv
// address map decoder for the emulation pod memories and target bus
`timescale 1ns/1ns
module emem_mapper
  import emem_map_pkg::*;
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          arst_n,
  // debugger settings
  input  cfg_mode_t          cfg_mode,
  input  area_cfg_t          area_cfg [AREA_COUNT],
  input  wire logic [7:0]    rom_bank,
  input  wire logic [23:0]   internal_top,
  input  wire logic [23:0]   reserved_lo,
  input  wire logic [23:0]   reserved_hi,
  input  wire logic          debug_start,
  // processor mode bit written by the user program
  input  wire logic          pm_bit_wr,
  input  wire logic          pm_bit_val,
  // mcu bus access
  input  wire logic          bus_valid,
  input  wire logic [23:0]   bus_addr,
  // memory contents loading
  input  wire logic          load_valid,
  input  wire logic [23:0]   load_addr,
  // target pins
  input  wire logic          pin_bus_width,
  input  wire logic          processor_mode_pin,
  input  wire logic          pin_wait_n,
  input  wire logic          pin_hold_n,
  input  wire logic          pin_nmi_n,
  // decode answer
  output target_t            sel_r,
  output logic               sel_valid_r,
  output logic [1:0]         exp_idx_r,
  output logic               exp_blocked_r,
  // load answer
  output logic               load_done_r,
  output logic               load_fast_r,
  // run state
  output run_mode_t          run_mode_r,
  // status
  output pin_status_t        pins_r,
  output logic               standby_r,
  output logic [3:0]         bank_err_r,
  output logic               budget_err_r,
  output logic               overlap_r
);

  // ==========================================================
  // helpers
  function automatic logic in_range(input logic [23:0] a,
                                    input logic [23:0] lo,
                                    input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic [1:0] first_hit(input logic [3:0] hits);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = AREA_COUNT - 1; i >= 0; i--) begin
      if (hits[i]) begin
        idx = i[1:0];
      end
    end
    first_hit = idx;
  endfunction : first_hit

  function automatic logic many_hits(input logic [3:0] hits);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < AREA_COUNT; i++) begin
      n = n + {2'h0, hits[i]};
    end
    many_hits = (n > 3'h1);
  endfunction : many_hits

  // ==========================================================
  // per-area decode
  logic [3:0]   bus_hit;
  logic [3:0]   load_hit;
  logic [23:0]  area_start [AREA_COUNT];

  genvar g;
  generate
    for (g = 0; g < AREA_COUNT; g++) begin : g_area
      area_match u_bus (
        .cfg   (area_cfg[g]),
        .addr  (bus_addr),
        .hit   (bus_hit[g]),
        .legal ()
      );
      area_match u_load (
        .cfg   (area_cfg[g]),
        .addr  (load_addr),
        .hit   (load_hit[g]),
        .legal ()
      );
    end
  endgenerate

  // ==========================================================
  // fixed ranges
  logic [7:0]   rom_bank_eff;
  logic [23:0]  rom_base;
  logic         in_regs_ram;
  logic         in_reserved;
  logic         in_vector;
  logic         in_rom;

  // the window never reaches below the top megabyte
  always_comb begin
    if (rom_bank < ROM_BANK_MIN) begin
      rom_bank_eff = ROM_BANK_MIN; // RULE_16
    end else begin
      rom_bank_eff = rom_bank;
    end
    rom_base = {rom_bank_eff, 16'h0000}; // RULE_16
  end

  assign in_regs_ram = (bus_addr < internal_top);
  assign in_reserved = in_range(bus_addr, reserved_lo, reserved_hi);
  assign in_vector   = in_range(bus_addr, VECTOR_BASE, TOP_ADDR);
  assign in_rom      = in_range(bus_addr, rom_base, TOP_ADDR);

  // ==========================================================
  // run mode
  logic         rom_mode;
  logic         exp_mode;

  assign rom_mode = (run_mode_r != RUN_MICRO);
  assign exp_mode = (run_mode_r == RUN_EXPAND) || (run_mode_r == RUN_MICRO);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      run_mode_r <= RUN_SINGLE;
    end else if (debug_start) begin
      case (cfg_mode)
        CFG_MICRO:  run_mode_r <= RUN_MICRO;
        default:    run_mode_r <= RUN_SINGLE; // RULE_18
      endcase
    end else if (pm_bit_wr) begin
      case (cfg_mode)
        CFG_EXPAND: run_mode_r <= pm_bit_val ? RUN_EXPAND : RUN_SINGLE; // RULE_18
        CFG_MICRO:  run_mode_r <= RUN_MICRO;
        default:    run_mode_r <= RUN_SINGLE;
      endcase
    end
  end

  // ==========================================================
  // bus decode
  target_t      sel_nxt;
  logic [1:0]   idx_nxt;
  logic         blocked_nxt;
  logic         area_hit;
  logic [1:0]   area_idx;
  map_t         area_map;

  assign area_hit = |bus_hit;
  assign area_idx = first_hit(bus_hit);
  assign area_map = area_cfg[area_idx].map;

  // priority: registers and ram, vector, rom window, reserved range, areas, target
  always_comb begin
    sel_nxt     = TARGET_RST;
    idx_nxt     = 2'h0;
    blocked_nxt = 1'b0;
    if (in_regs_ram) begin
      sel_nxt.internal = 1'b1; // RULE_14
    end else if (in_vector) begin
      sel_nxt.rom_emu = 1'b1; // RULE_13
    end else if (in_rom && rom_mode) begin
      sel_nxt.rom_emu = 1'b1; // RULE_15
    end else if (in_reserved) begin
      sel_nxt.internal = 1'b1; // RULE_08
    end else if (area_hit && area_map == MAP_INTERNAL) begin
      idx_nxt = area_idx;
      if (exp_mode) begin
        sel_nxt.exp_emu = 1'b1; // RULE_06
      end else begin
        blocked_nxt = 1'b1; // RULE_17
      end
    end else begin
      sel_nxt.external = 1'b1; // RULE_07
    end
  end

  // single-chip access to an internal expansion area finds nothing behind it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sel_r         <= TARGET_RST;
      sel_valid_r   <= 1'b0;
      exp_idx_r     <= 2'h0;
      exp_blocked_r <= 1'b0;
    end else begin
      sel_valid_r   <= bus_valid;
      sel_r         <= bus_valid ? sel_nxt : TARGET_RST; // RULE_08
      exp_idx_r     <= bus_valid ? idx_nxt : 2'h0; // RULE_01
      exp_blocked_r <= bus_valid & blocked_nxt; // RULE_17
    end
  end

  // ==========================================================
  // loading
  logic         load_fast_nxt;

  always_comb begin
    load_fast_nxt = 1'b0;
    for (int i = 0; i < AREA_COUNT; i++) begin
      if (load_hit[i] && area_cfg[i].map == MAP_EXTERNAL) begin
        load_fast_nxt = 1'b1; // RULE_09
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      load_done_r <= 1'b0;
      load_fast_r <= 1'b0;
    end else begin
      load_done_r <= load_valid;
      load_fast_r <= load_valid & load_fast_nxt; // RULE_09
    end
  end

  // ==========================================================
  // setting checks
  logic [4:0]   units_sum;
  logic [1:0]   cnt_1m;
  logic [2:0]   cnt_256k;
  logic         budget_nxt;

  // only internal areas draw on the pod memory
  always_comb begin
    units_sum = 5'h00;
    cnt_1m    = 2'h0;
    cnt_256k  = 3'h0;
    for (int i = 0; i < AREA_COUNT; i++) begin
      if (area_cfg[i].map == MAP_INTERNAL) begin
        if (area_cfg[i].len_1mb) begin
          units_sum = units_sum + {2'h0, UNITS_1M}; // RULE_10
          cnt_1m    = cnt_1m + 2'h1;
        end else begin
          units_sum = units_sum + {2'h0, UNITS_256K}; // RULE_03
          cnt_256k  = cnt_256k + 3'h1;
        end
      end
    end
    budget_nxt = (units_sum > UNITS_MAX) ||
                 (cnt_1m > MAX_1M_AREAS) ||
                 ((cnt_1m != 2'h0) && (cnt_256k > MAX_256K_WITH_1M)); // RULE_11
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bank_err_r   <= 4'h0;
      budget_err_r <= 1'b0;
    end else begin
      for (int i = 0; i < AREA_COUNT; i++) begin
        bank_err_r[i] <= (area_cfg[i].map != MAP_NOUSE) & (area_cfg[i].len_1mb ? // RULE_05
                         (area_start[i][POS_1M-1:POS_BANK] != 4'h0) :
                         (area_start[i][POS_256K-1:POS_BANK] != 2'h0)); // RULE_04
      end
      budget_err_r <= budget_nxt; // RULE_10
    end
  end

  // sticky; a new hit in the clearing cycle keeps it set
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      overlap_r <= 1'b0;
    end else if (bus_valid && many_hits(bus_hit)) begin
      overlap_r <= 1'b1; // RULE_12
    end else if (debug_start) begin
      overlap_r <= 1'b0;
    end
  end

  // ==========================================================
  // pin status
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pins_r <= PINS_RST;
    end else begin
      pins_r.bus_width <= pin_bus_width; // RULE_19
      pins_r.proc_mode <= processor_mode_pin; // RULE_19
      pins_r.wait_n    <= pin_wait_n; // RULE_19
      pins_r.hold_n    <= pin_hold_n; // RULE_19
      pins_r.nmi_n     <= pin_nmi_n; // RULE_19
    end
  end

  // the debugger only sees silence; this level tells it why
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      standby_r <= 1'b0;
    end else begin
      standby_r <= ~(pin_wait_n & pin_hold_n & pin_nmi_n); // RULE_20
    end
  end

  // ==========================================================
  // bank start
  // start address of an area is its bank in bits 23..16; alignment only
  // looks at the bits below its length, so no adder is needed

  generate
    for (g = 0; g < AREA_COUNT; g++) begin : g_start
      assign area_start[g] = {area_cfg[g].bank, 16'h0000}; // RULE_02
    end
  endgenerate

endmodule : emem_mapper

// File: dv/emem_mapper_asserts.sv
// concurrent checks on the ports of the area mapper
`timescale 1ns/1ns
module emem_mapper_chk
  import emem_map_pkg::*;
(
  // clock, reset and settings
  input wire logic        clock,
  input wire logic        arst_n,
  input cfg_mode_t        cfg_mode,
  input wire logic [23:0] internal_top,
  input wire logic        debug_start,
  input wire logic        pm_bit_wr,
  input wire logic        pm_bit_val,
  // requests and pins
  input wire logic        bus_valid,
  input wire logic [23:0] bus_addr,
  input wire logic        load_valid,
  input wire logic        pin_bus_width,
  input wire logic        processor_mode_pin,
  input wire logic        pin_wait_n,
  input wire logic        pin_hold_n,
  input wire logic        pin_nmi_n,
  // answers
  input target_t          sel_r,
  input wire logic        exp_blocked_r,
  input wire logic        load_done_r,
  input wire logic        load_fast_r,
  input run_mode_t        run_mode_r,
  input pin_status_t      pins_r,
  input wire logic        standby_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // run mode steps
  sequence s_start_plain;
    debug_start && cfg_mode != CFG_MICRO;
  endsequence
  sequence s_set_expand;
    pm_bit_wr && pm_bit_val && !debug_start && cfg_mode == CFG_EXPAND;
  endsequence
  chk_start_single: assert property (s_start_plain |=> run_mode_r == RUN_SINGLE)
    else $error("run mode not single after start");
  chk_pm_expand: assert property (s_set_expand |=> run_mode_r == RUN_EXPAND)
    else $error("mode bit write did not reach expansion");
  // ==========================================================
  // decode
  chk_regs_internal: assert property (bus_valid && bus_addr < internal_top |=> sel_r == 4'h2)
    else $error("register range not internal");
  chk_vector_rom: assert property (bus_valid && bus_addr >= VECTOR_BASE &&
    bus_addr >= internal_top |=> sel_r == 4'h8)
    else $error("vector area not from pod memory");
  chk_blocked_none: assert property (exp_blocked_r |-> sel_r == 4'h0 &&
    $past(run_mode_r) == RUN_SINGLE)
    else $error("blocked access selected something");
  chk_exp_mode: assert property (sel_r.exp_emu |-> $past(run_mode_r) != RUN_SINGLE)
    else $error("expansion memory reached in single-chip");
  chk_load_pair: assert property (load_fast_r |-> load_done_r && $past(load_valid))
    else $error("fast load without a load");
  // ==========================================================
  // pins
  chk_pins_follow: assert property (1'b1 |=> pins_r.wait_n == $past(pin_wait_n) &&
    pins_r.hold_n == $past(pin_hold_n) && pins_r.nmi_n == $past(pin_nmi_n) &&
    pins_r.bus_width == $past(pin_bus_width) && pins_r.proc_mode == $past(processor_mode_pin))
    else $error("pin status does not follow pins");
  chk_standby_flag: assert property (!(pin_wait_n && pin_hold_n && pin_nmi_n) |=> standby_r)
    else $error("standby not flagged");
endmodule : emem_mapper_chk

bind emem_mapper emem_mapper_chk u_chk (.clock, .arst_n, .cfg_mode, .internal_top, .debug_start,
  .pm_bit_wr, .pm_bit_val, .bus_valid, .bus_addr, .load_valid, .pin_bus_width,
  .processor_mode_pin, .pin_wait_n, .pin_hold_n, .pin_nmi_n, .sel_r, .exp_blocked_r,
  .load_done_r, .load_fast_r, .run_mode_r, .pins_r, .standby_r);

// File: dv/target_pin_model.sv
// target side pins: mode pin and handshake lines with pull-ups
`timescale 1ns/1ns
module target_pin_model (
  // control from the bench
  input  wire logic       clock,
  input  wire logic       mode_hi,
  input  wire logic [2:0] stall,
  // pins towards the pod
  output logic            pin_bus_width,
  output logic            processor_mode_pin,
  output logic            pin_wait_n,
  output logic            pin_hold_n,
  output logic            pin_nmi_n
);
  // ==========================================================
  // levels move on edges only; a released handshake line sits at its pull-up
  initial {pin_bus_width, processor_mode_pin, pin_wait_n, pin_hold_n, pin_nmi_n} = 5'h07;
  always @(posedge clock) begin
    pin_bus_width <= mode_hi;
    processor_mode_pin <= mode_hi;
    {pin_wait_n, pin_hold_n, pin_nmi_n} <= ~stall;
  end
endmodule : target_pin_model

// File: dv/emem_mapper_test.sv
// self-checking bench for the emulation memory area mapper
`timescale 1ns/1ns
module emem_mapper_test;
  import emem_map_pkg::*;
  logic        clock = 1'b0, arst_n = 1'b0, debug_start = 1'b0, pm_bit_wr = 1'b0;
  logic        pm_bit_val = 1'b0, bus_valid = 1'b0, load_valid = 1'b0, mode_hi = 1'b0;
  logic [2:0]  stall = 3'h0;
  logic [7:0]  rom_bank = 8'hf8;
  logic [23:0] internal_top = 24'h000400, reserved_lo = 24'h00fc00, reserved_hi = 24'h00ffff;
  logic [23:0] bus_addr = 24'h0, load_addr = 24'h0;
  cfg_mode_t   cfg_mode = CFG_EXPAND;
  area_cfg_t   area_cfg [AREA_COUNT];
  target_t     sel_r;
  run_mode_t   run_mode_r;
  pin_status_t pins_r;
  logic [3:0]  bank_err_r;
  logic [1:0]  exp_idx_r;
  logic        sel_valid_r, exp_blocked_r, load_done_r, load_fast_r, standby_r;
  logic        budget_err_r, overlap_r, pin_bus_width, processor_mode_pin;
  logic        pin_wait_n, pin_hold_n, pin_nmi_n;
  logic [29:0] rows [12];
  int          n_fail = 0, n_tests = 0;

  emem_mapper dut (.clock, .arst_n, .cfg_mode, .area_cfg, .rom_bank, .internal_top,
    .reserved_lo, .reserved_hi, .debug_start, .pm_bit_wr, .pm_bit_val, .bus_valid, .bus_addr,
    .load_valid, .load_addr, .pin_bus_width, .processor_mode_pin, .pin_wait_n, .pin_hold_n,
    .pin_nmi_n, .sel_r, .sel_valid_r, .exp_idx_r, .exp_blocked_r, .load_done_r, .load_fast_r,
    .run_mode_r, .pins_r, .standby_r, .bank_err_r, .budget_err_r, .overlap_r);
  target_pin_model u_pins (.clock, .mode_hi, .stall, .pin_bus_width, .processor_mode_pin,
    .pin_wait_n, .pin_hold_n, .pin_nmi_n);

  always #50 clock = ~clock;

  // ==========================================================
  // helpers
  task step;
    @(posedge clock);
    #1;
  endtask : step
  task cmp(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task bus(input logic [23:0] a);
    bus_valid = 1'b1;
    bus_addr = a;
    step;
  endtask : bus
  task start;
    debug_start = 1'b1;
    step;
    debug_start = 1'b0;
  endtask : start
  task wrap_up;
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (2000) @(posedge clock);
    n_fail++;
    wrap_up;
  end

  // ==========================================================
  // main sequence
  initial begin
    // legal mix, no overlap, within the budget
    area_cfg = '{'{8'h10, 1'b0, MAP_INTERNAL}, '{8'h20, 1'b1, MAP_INTERNAL},
      '{8'h40, 1'b0, MAP_EXTERNAL}, '{8'hc0, 1'b0, MAP_NOUSE}};
    rows = '{{24'h000100, 4'h2, 2'h0}, {24'h00fd00, 4'h2, 2'h0}, {24'h13fffc, 4'h4, 2'h0},
      {24'h140000, 4'h1, 2'h0}, {24'h2ffffe, 4'h4, 2'h1}, {24'h300000, 4'h1, 2'h0},
      {24'h400010, 4'h1, 2'h0}, {24'hc00000, 4'h1, 2'h0}, {24'hf7fffe, 4'h1, 2'h0},
      {24'hf80000, 4'h8, 2'h0}, {24'hffff00, 4'h8, 2'h0}, {24'h0ffffe, 4'h1, 2'h0}};
    repeat (12) @(posedge clock);
    cmp("run", 8'(run_mode_r), 8'h1);
    cmp("pins", 8'(pins_r), 8'h07);
    #1 arst_n = 1'b1;
    start;
    cmp("run", 8'(run_mode_r), 8'h1);
    bus(24'h100000);
    cmp("blocked", 8'(exp_blocked_r), 8'h1);
    cmp("sel", 8'(sel_r), 8'h0);
    {pm_bit_wr, pm_bit_val} = 2'b11;
    step;
    pm_bit_wr = 1'b0;
    cmp("run", 8'(run_mode_r), 8'h2);
    foreach (rows[i]) begin
      bus(rows[i][29:6]);
      cmp("valid", 8'(sel_valid_r), 8'h1);
      cmp("sel", 8'(sel_r), 8'(rows[i][5:2]));
      cmp("idx", 8'(exp_idx_r), 8'(rows[i][1:0]));
    end
    // widened rom window; a bank below the top megabyte is clamped
    rom_bank = 8'hf0;
    bus(24'hf00000);
    cmp("sel", 8'(sel_r), 8'h8);
    rom_bank = 8'he0;
    bus(24'hefffff);
    cmp("sel", 8'(sel_r), 8'h1);
    bus_valid = 1'b0;
    // back-to-back loads: only an explicit external area is fast
    foreach (rows[i]) if (i < 4) begin
      load_valid = 1'b1;
      load_addr = i == 0 ? 24'h400000 : rows[i + 2][29:6];
      step;
      cmp("fast", {load_done_r, load_fast_r}, i == 0 ? 8'h3 : 8'h2);
    end
    load_valid = 1'b0;
    // each handshake line low in turn
    mode_hi = 1'b1;
    for (int i = 0; i < 3; i++) begin
      stall = 3'(1 << i);
      step;
      step;
      cmp("pins", 8'(pins_r), {3'h0, 2'b11, ~stall});
      cmp("standby", 8'(standby_r), 8'h1);
    end
    stall = 3'h0;
    step;
    step;
    cmp("standby", 8'(standby_r), 8'h0);
    // misaligned banks never hit
    area_cfg[1] = '{8'h28, 1'b1, MAP_INTERNAL};
    area_cfg[3] = '{8'hc2, 1'b0, MAP_INTERNAL};
    bus(24'hc20000);
    cmp("sel", 8'(sel_r), 8'h1);
    cmp("bank_err", 8'(bank_err_r), 8'h0a);
    // overlapping areas: lowest index wins and the flag sticks
    area_cfg[1] = '{8'h20, 1'b1, MAP_INTERNAL};
    area_cfg[3] = '{8'h10, 1'b0, MAP_INTERNAL};
    bus(24'h100000);
    cmp("idx", 8'(exp_idx_r), 8'h0);
    cmp("overlap", 8'(overlap_r), 8'h1);
    // a start in the same cycle as a new double hit keeps the flag, a plain start clears it
    debug_start = 1'b1;
    bus(24'h100000);
    cmp("overlap", 8'(overlap_r), 8'h1);
    bus_valid = 1'b0;
    step;
    debug_start = 1'b0;
    cmp("overlap", 8'(overlap_r), 8'h0);
    cmp("valid", 8'(sel_valid_r), 8'h0);
    // 1 MB plus three 256 KB is refused, four 256 KB is not
    area_cfg[2] = '{8'h40, 1'b0, MAP_INTERNAL};
    area_cfg[3] = '{8'hc0, 1'b0, MAP_INTERNAL};
    step;
    cmp("budget", 8'(budget_err_r), 8'h1);
    area_cfg[1] = '{8'h80, 1'b0, MAP_INTERNAL};
    step;
    cmp("budget", 8'(budget_err_r), 8'h0);
    // 1 MB plus two 256 KB fills the memory exactly and is allowed
    area_cfg[1] = '{8'h80, 1'b1, MAP_INTERNAL};
    area_cfg[3] = '{8'hc0, 1'b0, MAP_NOUSE};
    step;
    cmp("budget", 8'(budget_err_r), 8'h0);
    // microprocessor mode: rom window goes out, vector stays in the pod
    cfg_mode = CFG_MICRO;
    start;
    cmp("run", 8'(run_mode_r), 8'h4);
    bus(24'hf80000);
    cmp("sel", 8'(sel_r), 8'h1);
    bus(24'hffff00);
    cmp("sel", 8'(sel_r), 8'h8);
    bus(24'h100000);
    cmp("sel", 8'(sel_r), 8'h4);
    // reset in mid-run: outputs drop at once, the first edge after release decodes
    bus_valid = 1'b0;
    arst_n = 1'b0;
    step;
    cmp("sel", 8'(sel_r), 8'h0);
    cmp("run", 8'(run_mode_r), 8'h1);
    cmp("pins", 8'(pins_r), 8'h07);
    arst_n = 1'b1;
    cfg_mode = CFG_SINGLE;
    {pm_bit_wr, pm_bit_val} = 2'b11;
    bus(24'h000100);
    pm_bit_wr = 1'b0;
    cmp("sel", 8'(sel_r), 8'h2);
    cmp("run", 8'(run_mode_r), 8'h1);
    wrap_up;
  end
endmodule : emem_mapper_test
